// ### design/rfrx_regs.sv
// rfrx_regs: receiver configuration register bank with framing control
//
// Operation
// R01: partial final byte still written to FIFO with CRC on when permit set
// R02: multi-frame mode keeps receiver active after a frame ends
// R03: multi-frame mode appends error register copy byte after each frame
// R04: suppression on: error in first three bytes discards them, FIFO reset
// R05: frames discarded by suppression never raise receive-done flag
// R06: host waits for three bytes when forced check write and suppression
// R07: baud field 2 selects 26 kBd, 3 selects 52 kBd, others reserved
// R08: guard unit 0 is 16 carrier cycles, 1 is half bit period
// R09: after each transmission input ignored for count times unit
// R10: upper threshold nibble sets decoder minimum level
// R11: lower threshold nibble sets phase detector minimum level
// R12: input mode bit selects differential or quasi-differential input
// R13: converter bit selects normal reception or low-power card detection
// R14: source field selects idle, analog, envelope or generic input
// R15: collision field sets 1/8, 1/4, 1/2 threshold; 3 disables
// R16: analog register forwards baseband gain and high-pass corner
// R17: half-bit time base follows selected bit stream frequency
// R18: reserved bits read zero and ignore writes
`timescale 1ns/1ps
module rfrx_regs
	import rfrx_pkg::*;
#(
	parameter int CLOCK_KHZ = CLK_KHZ
)(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// receive path events
	input  wire logic        rx_start_i,
	input  wire logic        rx_stop_i,
	input  wire logic        tx_done_i,
	input  wire logic        rx_sof_i,
	input  wire logic        rx_byte_valid_i,
	input  wire logic [7:0]  rx_byte_i,
	input  wire logic        rx_byte_partial_i,
	input  wire logic        rx_error_i,
	input  wire logic        rx_frame_end_i,
	input  wire logic        crc_enable_i,
	input  wire logic        forced_check_write_i,
	input  wire logic [7:0]  error_reg_i,
	input  wire logic [1:0]  bit_stream_frequency_i,
	// fifo side
	output logic             fifo_wr_o,
	output logic      [7:0]  fifo_wdata_o,
	output logic             fifo_reset_o,
	output logic             fifo_read_safe_o,
	// receiver status and static controls
	output logic             receiver_active_o,
	output logic             receiver_ignore_o,
	output logic             baud_52k_o,
	output logic             baud_reserved_o,
	output logic      [3:0]  decoder_min_level_o,
	output logic      [3:0]  phase_detector_min_level_o,
	output logic             quasi_differential_o,
	output logic             converter_mode_o,
	output logic      [1:0]  signal_source_select_o,
	output logic             collision_detect_en_o,
	output logic      [1:0]  collision_sensitivity_o,
	output logic      [1:0]  factory_trim_field_o,
	output logic      [1:0]  rcv_hpcf_o,
	output logic      [1:0]  rcv_gain_o,
	// interrupt
	output logic             irq_o
);

	// time base products overflow int above 100 MHz; guard assertions need a carrier unit of 8 cycles or more
	if (CLOCK_KHZ < 8000 || CLOCK_KHZ > 100000)
	begin : g_bad_clock
		$error("rfrx_regs: CLOCK_KHZ out of range");
	end

	// ***************************************************************
	// time bases
	// ***************************************************************
	localparam int UNIT_W = 12;

	function automatic logic [UNIT_W-1:0] cycles_of(input int ns);
		cycles_of = UNIT_W'((ns * CLOCK_KHZ + 999999) / 1000000);
	endfunction

	localparam logic [UNIT_W-1:0] CARRIER_CYC = cycles_of(CARRIER_UNIT_NS);

	function automatic logic [UNIT_W-1:0] half_bit_cyc(input logic [1:0] code);
		case (code)
			2'h0:    half_bit_cyc = cycles_of(HALF_BIT_NS_0);
			2'h1:    half_bit_cyc = cycles_of(HALF_BIT_NS_1);
			2'h2:    half_bit_cyc = cycles_of(HALF_BIT_NS_2);
			default: half_bit_cyc = cycles_of(HALF_BIT_NS_3);
		endcase
	endfunction

	// ***************************************************************
	// registers
	// ***************************************************************
	logic [7:0] framing_ctrl;
	logic [7:0] guard_time;
	logic [7:0] threshold;
	logic [7:0] input_select;
	logic [7:0] analog_setup;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] irq_set;

	logic       wr_pend;
	logic       rd_pend;
	logic [7:0] acc_idx;

	// ahb address phase capture
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			acc_idx <= 8'h00;
		end
		else if (hready_i)
		begin
			wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
			rd_pend <= hsel_i && htrans_i[1] && !hwrite_i;
			acc_idx <= haddr_i[9:2];
		end
		else if (rd_pend)
			rd_pend <= 1'b0;
	end

	// reads take one wait state so data come from a flip-flop
	assign hreadyout_o = !rd_pend;
	assign hresp_o     = 1'b0;

	function automatic logic [7:0] read_mux(input logic [7:0] idx);
		case (idx)
			IDX_FRAMING_CTRL: read_mux = framing_ctrl;
			IDX_GUARD_TIME:   read_mux = guard_time;
			IDX_THRESHOLD:    read_mux = threshold;
			IDX_INPUT_SELECT: read_mux = input_select;
			IDX_ANALOG_SETUP: read_mux = analog_setup;
			IDX_IRQ_STATUS:   read_mux = irq_status;
			IDX_IRQ_MASK:     read_mux = irq_mask;
			IDX_RX_STATE:     read_mux = {5'h00, fifo_read_safe_o, receiver_ignore_o, receiver_active_o};
			default:          read_mux = 8'h00;
		endcase
	endfunction

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			hrdata_o <= 32'h00000000;
		else if (rd_pend)
			hrdata_o <= {24'h000000, read_mux(acc_idx)};
	end

	// configuration writes, reserved bits masked off
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			framing_ctrl <= RESET_VALUE;
			guard_time   <= RESET_VALUE;
			threshold    <= RESET_VALUE;
			input_select <= RESET_VALUE;
			analog_setup <= RESET_VALUE;
			irq_mask     <= RESET_VALUE;
		end
		else if (wr_pend)
		begin
			case (acc_idx)
				IDX_FRAMING_CTRL: framing_ctrl <= hwdata_i[7:0] & MASK_FRAMING_CTRL; // R18
				IDX_GUARD_TIME:   guard_time   <= hwdata_i[7:0] & MASK_GUARD_TIME;
				IDX_THRESHOLD:    threshold    <= hwdata_i[7:0] & MASK_THRESHOLD;
				IDX_INPUT_SELECT: input_select <= hwdata_i[7:0] & MASK_INPUT_SELECT; // R18
				IDX_ANALOG_SETUP: analog_setup <= hwdata_i[7:0] & MASK_ANALOG_SETUP; // R18
				IDX_IRQ_MASK:     irq_mask     <= hwdata_i[7:0] & MASK_IRQ;
				default:          ;
			endcase
		end
	end

	// sticky status, write one to clear, a new event wins
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			irq_status <= RESET_VALUE;
		else if (wr_pend && acc_idx == IDX_IRQ_STATUS)
			irq_status <= ((irq_status & ~hwdata_i[7:0]) | irq_set) & MASK_IRQ;
		else
			irq_status <= (irq_status | irq_set) & MASK_IRQ;
	end

	assign irq_o = |(irq_status & irq_mask);

	// ***************************************************************
	// static controls
	// ***************************************************************
	wire       partial_byte_permit      = framing_ctrl[FC_PARTIAL_BIT];
	wire       multi_frame_receive      = framing_ctrl[FC_MULTI_BIT];
	wire       interference_suppress_en = framing_ctrl[FC_SUPPRESS_BIT];
	wire [2:0] baud_field               = framing_ctrl[FC_BAUD_LSB +: 3];
	wire       guard_time_unit          = guard_time[GT_UNIT_BIT];

	assign baud_52k_o                 = (baud_field == BAUD_52K); // R07
	assign baud_reserved_o            = (baud_field != BAUD_26K) && (baud_field != BAUD_52K); // R07
	assign decoder_min_level_o        = threshold[TH_DECODER_LSB +: 4]; // R10
	assign phase_detector_min_level_o = threshold[TH_PHASE_LSB +: 4]; // R11
	assign quasi_differential_o       = input_select[IS_SINGLE_BIT]; // R12
	assign converter_mode_o           = input_select[IS_ADC_BIT]; // R13
	assign signal_source_select_o     = input_select[IS_SOURCE_LSB +: 2]; // R14
	assign collision_sensitivity_o    = input_select[IS_COLL_LSB +: 2]; // R15
	assign collision_detect_en_o      = (collision_sensitivity_o != COLL_OFF); // R15
	assign factory_trim_field_o       = analog_setup[AS_TRIM_LSB +: 2];
	assign rcv_hpcf_o                 = analog_setup[AS_HPCF_LSB +: 2]; // R16
	assign rcv_gain_o                 = analog_setup[AS_GAIN_LSB +: 2]; // R16

	// ***************************************************************
	// post-transmit guard window
	// ***************************************************************
	logic [6:0]        guard_cnt;
	logic [UNIT_W-1:0] unit_cnt;
	logic [UNIT_W-1:0] unit_len;

	// half-bit base follows the bit stream frequency
	assign unit_len = guard_time_unit ? half_bit_cyc(bit_stream_frequency_i) : CARRIER_CYC; // R08 R17

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			guard_cnt <= 7'h00;
			unit_cnt  <= '0;
		end
		else if (tx_done_i)
		begin
			guard_cnt <= guard_time[GT_COUNT_LSB +: 7]; // R09
			unit_cnt  <= unit_len - UNIT_W'(1);
		end
		else if (guard_cnt != 7'h00)
		begin
			if (unit_cnt == '0)
			begin
				guard_cnt <= guard_cnt - 7'h01;
				unit_cnt  <= unit_len - UNIT_W'(1); // R08
			end
			else
				unit_cnt <= unit_cnt - UNIT_W'(1);
		end
	end

	assign receiver_ignore_o = (guard_cnt != 7'h00); // R09

	// ***************************************************************
	// frame handling
	// ***************************************************************
	rfrx_state_t state;
	logic [1:0]  byte_cnt;
	logic        guard_was;

	wire sof_ok   = rx_sof_i && !receiver_ignore_o;
	wire byte_ok  = rx_byte_valid_i && !receiver_ignore_o && state == RFRX_FRAME;
	wire err_ok   = rx_error_i && !receiver_ignore_o && state == RFRX_FRAME;
	wire end_ok   = rx_frame_end_i && !receiver_ignore_o && state == RFRX_FRAME;
	wire early    = interference_suppress_en && byte_cnt < EMD_BYTES;
	wire discard  = early && (err_ok || end_ok); // R04 R05
	wire keep_end = end_ok && !discard;
	wire store_ok = byte_ok && !discard && (!rx_byte_partial_i || !crc_enable_i || partial_byte_permit); // R01

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			state <= RFRX_IDLE;
		else if (rx_stop_i)
			state <= RFRX_IDLE;
		else
		begin
			case (state)
				RFRX_IDLE:   if (rx_start_i) state <= RFRX_LISTEN;
				RFRX_LISTEN: if (sof_ok) state <= RFRX_FRAME;
				RFRX_FRAME:
				begin
					if (discard)
						state <= RFRX_LISTEN;
					else if (keep_end)
						state <= multi_frame_receive ? RFRX_LISTEN : RFRX_IDLE; // R02
				end
				default:     state <= RFRX_IDLE;
			endcase
		end
	end

	assign receiver_active_o = (state != RFRX_IDLE);

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || state != RFRX_FRAME)
			byte_cnt <= 2'h0;
		else if (byte_ok && byte_cnt != EMD_BYTES)
			byte_cnt <= byte_cnt + 2'h1;
	end

	// fifo writes: data bytes, then the error copy in multi-frame mode
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			fifo_wr_o    <= 1'b0;
			fifo_wdata_o <= 8'h00;
			fifo_reset_o <= 1'b0;
		end
		else
		begin
			fifo_reset_o <= discard; // R04
			fifo_wr_o    <= store_ok || (keep_end && multi_frame_receive);
			if (keep_end && multi_frame_receive)
				fifo_wdata_o <= error_reg_i; // R03
			else if (store_ok)
				fifo_wdata_o <= rx_byte_i;
		end
	end

	// the host may read early only when no forced write can be undone
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			fifo_read_safe_o <= 1'b1;
		else
			fifo_read_safe_o <= !(forced_check_write_i && interference_suppress_en)
				|| state != RFRX_FRAME || byte_cnt == EMD_BYTES; // R06
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			guard_was <= 1'b0;
		else
			guard_was <= receiver_ignore_o;
	end

	always_comb
	begin
		irq_set              = 8'h00;
		irq_set[IRQ_RX_DONE] = keep_end; // R05
		irq_set[IRQ_DISCARD] = discard;
		irq_set[IRQ_GUARD_END] = guard_was && !receiver_ignore_o;
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	localparam int CARRIER_INT = int'(CARRIER_CYC);
	localparam int GUARD_LO    = CARRIER_INT - 8;
	localparam int GUARD_HI    = CARRIER_INT - 7;

	sequence s_multi_end;
		keep_end && multi_frame_receive;
	endsequence

	sequence s_early_error;
		interference_suppress_en && err_ok && byte_cnt < EMD_BYTES;
	endsequence

	property p_stay_active;
		@(posedge ref_clk_i) disable iff (rst_i) (s_multi_end and !rx_stop_i) |=> receiver_active_o;
	endproperty
	a_stay_active: assert property (p_stay_active) else $error("receiver stopped in multi-frame mode"); // R02

	property p_error_byte;
		@(posedge ref_clk_i) disable iff (rst_i) s_multi_end |=> fifo_wr_o && fifo_wdata_o == $past(error_reg_i);
	endproperty
	a_error_byte: assert property (p_error_byte) else $error("error byte not appended"); // R03

	property p_emd_reset;
		@(posedge ref_clk_i) disable iff (rst_i) s_early_error |=> fifo_reset_o && !fifo_wr_o ##1 !fifo_reset_o;
	endproperty
	a_emd_reset: assert property (p_emd_reset) else $error("early error did not reset fifo"); // R04

	property p_no_irq_discard;
		@(posedge ref_clk_i) disable iff (rst_i) discard |-> !irq_set[IRQ_RX_DONE] ##1 fifo_reset_o;
	endproperty
	a_no_irq_discard: assert property (p_no_irq_discard) else $error("discarded frame raised done flag"); // R05

	property p_partial;
		@(posedge ref_clk_i) disable iff (rst_i)
			byte_ok && !discard && rx_byte_partial_i && crc_enable_i |=> fifo_wr_o == $past(partial_byte_permit);
	endproperty
	a_partial: assert property (p_partial) else $error("partial byte handling wrong"); // R01

	property p_baud;
		@(posedge ref_clk_i) disable iff (rst_i) baud_field == BAUD_26K |-> !baud_52k_o && !baud_reserved_o;
	endproperty
	a_baud: assert property (p_baud) else $error("26 kBd selection wrong"); // R07

	property p_guard_start;
		@(posedge ref_clk_i) disable iff (rst_i)
			tx_done_i && guard_time[GT_COUNT_LSB +: 7] != 7'h00 |=> receiver_ignore_o [*8];
	endproperty
	a_guard_start: assert property (p_guard_start) else $error("guard window too short"); // R09

	property p_guard_unit;
		@(posedge ref_clk_i) disable iff (rst_i)
			tx_done_i && guard_time == 8'h01 |=> receiver_ignore_o [*8] ##[GUARD_LO:GUARD_HI] !receiver_ignore_o;
	endproperty
	a_guard_unit: assert property (p_guard_unit) else $error("carrier unit length wrong"); // R08

	property p_coll_off;
		@(posedge ref_clk_i) disable iff (rst_i) collision_detect_en_o == (input_select[1:0] != COLL_OFF);
	endproperty
	a_coll_off: assert property (p_coll_off) else $error("collision enable wrong"); // R15

	property p_reserved_zero;
		@(posedge ref_clk_i) disable iff (rst_i)
			rd_pend && acc_idx == IDX_FRAMING_CTRL |=> hrdata_o[5:4] == 2'h0 && hrdata_o[31:8] == 24'h000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // R18

endmodule // rfrx_regs

// ### common/rfrx_pkg.sv
// rfrx_pkg: constants of the receiver configuration register bank
package rfrx_pkg;

	// ***************************************************************
	// register indices, byte address is four times the index
	// ***************************************************************
	localparam logic [7:0] IDX_FRAMING_CTRL = 8'h35;
	localparam logic [7:0] IDX_GUARD_TIME   = 8'h36;
	localparam logic [7:0] IDX_THRESHOLD    = 8'h37;
	localparam logic [7:0] IDX_INPUT_SELECT = 8'h38;
	localparam logic [7:0] IDX_ANALOG_SETUP = 8'h39;
	localparam logic [7:0] IDX_IRQ_STATUS   = 8'h40;
	localparam logic [7:0] IDX_IRQ_MASK     = 8'h41;
	localparam logic [7:0] IDX_RX_STATE     = 8'h42;

	// ***************************************************************
	// writable bits per register, reserved bits stay zero
	// ***************************************************************
	localparam logic [7:0] MASK_FRAMING_CTRL = 8'hCF;
	localparam logic [7:0] MASK_GUARD_TIME   = 8'hFF;
	localparam logic [7:0] MASK_THRESHOLD    = 8'hFF;
	localparam logic [7:0] MASK_INPUT_SELECT = 8'hF3;
	localparam logic [7:0] MASK_ANALOG_SETUP = 8'hCF;
	localparam logic [7:0] MASK_IRQ          = 8'h07;
	localparam logic [7:0] RESET_VALUE       = 8'h00;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int FC_PARTIAL_BIT  = 7;
	localparam int FC_MULTI_BIT    = 6;
	localparam int FC_SUPPRESS_BIT = 3;
	localparam int FC_BAUD_LSB     = 0;
	localparam int GT_UNIT_BIT     = 7;
	localparam int GT_COUNT_LSB    = 0;
	localparam int TH_DECODER_LSB  = 4;
	localparam int TH_PHASE_LSB    = 0;
	localparam int IS_SINGLE_BIT   = 7;
	localparam int IS_ADC_BIT      = 6;
	localparam int IS_SOURCE_LSB   = 4;
	localparam int IS_COLL_LSB     = 0;
	localparam int AS_TRIM_LSB     = 6;
	localparam int AS_HPCF_LSB     = 2;
	localparam int AS_GAIN_LSB     = 0;
	localparam int IRQ_RX_DONE     = 0;
	localparam int IRQ_DISCARD     = 1;
	localparam int IRQ_GUARD_END   = 2;

	// ***************************************************************
	// encodings
	// ***************************************************************
	localparam logic [2:0] BAUD_26K      = 3'h2;
	localparam logic [2:0] BAUD_52K      = 3'h3;
	localparam logic [1:0] COLL_OFF      = 2'h3;
	localparam logic [1:0] EMD_BYTES     = 2'h3;

	// ***************************************************************
	// timing: carrier unit and half-bit periods per bit stream code
	// ***************************************************************
	localparam int CLK_KHZ        = 40000;
	localparam int CARRIER_UNIT_NS = 1180;
	localparam int HALF_BIT_NS_0  = 18880;
	localparam int HALF_BIT_NS_1  = 9440;
	localparam int HALF_BIT_NS_2  = 4720;
	localparam int HALF_BIT_NS_3  = 2360;

	typedef enum logic [1:0] {RFRX_IDLE, RFRX_LISTEN, RFRX_FRAME} rfrx_state_t;

endpackage

// ### tb/rfrx_testbench.sv
// testbench: self-checking bench of the receiver configuration register bank
`timescale 1ns/1ps
module testbench
	import rfrx_pkg::*;
;
	// ***************************************************************
	// signals
	// ***************************************************************
	logic        ref_clk_i, rst_i, hsel_i, hwrite_i, crc_enable_i, forced_check_write_i, rx_byte_partial_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rdata;
	logic [1:0]  htrans_i, bit_stream_frequency_i;
	logic [7:0]  rx_byte_i, error_reg_i, fifo_wdata_o;
	logic [6:0]  ev;
	logic        hreadyout_o, hresp_o, fifo_wr_o, fifo_reset_o, fifo_read_safe_o, receiver_active_o;
	logic        receiver_ignore_o, baud_52k_o, baud_reserved_o, quasi_differential_o, converter_mode_o;
	logic        collision_detect_en_o, irq_o;
	logic [3:0]  decoder_min_level_o, phase_detector_min_level_o;
	logic [1:0]  signal_source_select_o, collision_sensitivity_o, factory_trim_field_o, rcv_hpcf_o, rcv_gain_o;
	int          err_count, num_checks, code, i;
	integer      seed;
	logic [7:0]  d, er;
	logic [7:0]  idx_t [5] = '{IDX_FRAMING_CTRL, IDX_GUARD_TIME, IDX_THRESHOLD, IDX_INPUT_SELECT, IDX_ANALOG_SETUP};
	logic [7:0]  msk_t [5] = '{MASK_FRAMING_CTRL, MASK_GUARD_TIME, MASK_THRESHOLD, MASK_INPUT_SELECT, MASK_ANALOG_SETUP};
	int          half_t [4] = '{756, 378, 189, 95};

	rfrx_regs dut_u (
		.ref_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
		.hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
		.rx_start_i(ev[0]), .rx_stop_i(ev[1]), .tx_done_i(ev[2]), .rx_sof_i(ev[3]), .rx_byte_valid_i(ev[4]),
		.rx_byte_i, .rx_byte_partial_i, .rx_error_i(ev[5]), .rx_frame_end_i(ev[6]), .crc_enable_i,
		.forced_check_write_i, .error_reg_i, .bit_stream_frequency_i,
		.fifo_wr_o, .fifo_wdata_o, .fifo_reset_o, .fifo_read_safe_o, .receiver_active_o, .receiver_ignore_o,
		.baud_52k_o, .baud_reserved_o, .decoder_min_level_o, .phase_detector_min_level_o, .quasi_differential_o,
		.converter_mode_o, .signal_source_select_o, .collision_detect_en_o, .collision_sensitivity_o,
		.factory_trim_field_o, .rcv_hpcf_o, .rcv_gain_o, .irq_o
	);

	// ***************************************************************
	// tasks
	// ***************************************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one single-word transfer, read data lands in rdata
	task bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
		@(posedge ref_clk_i);
		hsel_i   <= 1'b1;
		haddr_i  <= {22'h0, idx, 2'b00};
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		rdata = hrdata_o;
	endtask

	task settle;
		@(posedge ref_clk_i);
		#1;
	endtask

	// one-cycle event pulse, returns just after the sampling edge
	task ev_pulse(input logic [6:0] m, input logic [7:0] b, input logic p);
		@(posedge ref_clk_i);
		ev                <= m;
		rx_byte_i         <= b;
		rx_byte_partial_i <= p;
		@(posedge ref_clk_i);
		ev <= 7'h00;
		#1;
	endtask

	// ignore window length in clock cycles after one end of transmission
	task guard(input logic [7:0] g, input int exp);
		int n;
		bus(IDX_GUARD_TIME, 1'b1, {24'h0, g});
		ev_pulse(7'h04, 8'h00, 1'b0);
		n = 0;
		while (receiver_ignore_o !== 1'b1 && n < 3)
		begin
			settle();
			n++;
		end
		n = 0;
		while (receiver_ignore_o === 1'b1 && n < 2000)
		begin
			settle();
			n++;
		end
		chk(32'(n), 32'(exp));
	endtask

	// ***************************************************************
	// clock, watchdog, main sequence
	// ***************************************************************
	initial
	begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		err_count++;
		give_verdict();
	end

	initial
	begin
		seed = 84605;
		err_count = 0;
		num_checks = 0;
		code = $random(seed) & 3;
		er = 8'($random(seed));
		rst_i = 1'b1; hsel_i = 1'b0; haddr_i = 32'h0; htrans_i = 2'h0; hwrite_i = 1'b0; hwdata_i = 32'h0;
		ev = 7'h00; rx_byte_i = 8'h00; rx_byte_partial_i = 1'b0; crc_enable_i = 1'b1;
		forced_check_write_i = 1'b1; error_reg_i = er; bit_stream_frequency_i = code[1:0];
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 5; i++)
		begin
			bus(idx_t[i], 1'b0, 32'h0);
			chk(rdata, 32'h0);
			d = 8'($random(seed));
			bus(idx_t[i], 1'b1, 32'({$random(seed), d}));
			bus(idx_t[i], 1'b0, 32'h0);
			chk(rdata, {24'h0, d & msk_t[i]});
		end
		bus(8'h50, 1'b1, 32'hFF);
		bus(8'h50, 1'b0, 32'h0);
		chk(rdata, 32'h0);
		chk(hresp_o, 1'b0);
		d = 8'($random(seed));
		bus(IDX_THRESHOLD, 1'b1, {24'h0, d});
		settle();
		chk(decoder_min_level_o, d[7:4]);
		chk(phase_detector_min_level_o, d[3:0]);
		for (i = 0; i < 8; i++)
		begin
			bus(IDX_FRAMING_CTRL, 1'b1, 32'(i));
			bus(IDX_INPUT_SELECT, 1'b1, {24'h0, i[0], i[1], i[1:0], 2'b00, i[1:0]});
			bus(IDX_ANALOG_SETUP, 1'b1, {24'h0, i[1:0], 2'b00, i[1:0], i[1:0]});
			settle();
			chk(baud_52k_o, i == 3);
			chk(baud_reserved_o, i != 2 && i != 3);
			chk({quasi_differential_o, converter_mode_o}, {i[0], i[1]});
			chk(signal_source_select_o, i[1:0]);
			chk({collision_detect_en_o, collision_sensitivity_o}, {i[1:0] != 2'h3, i[1:0]});
			chk({factory_trim_field_o, rcv_hpcf_o, rcv_gain_o}, {3{i[1:0]}});
		end
		bus(IDX_FRAMING_CTRL, 1'b1, 32'h40);
		ev_pulse(7'h01, 8'h00, 1'b0);
		ev_pulse(7'h08, 8'h00, 1'b0);
		d = 8'($random(seed));
		ev_pulse(7'h10, d, 1'b0);
		chk({fifo_wr_o, fifo_wdata_o}, {1'b1, d});
		ev_pulse(7'h10, d, 1'b1);
		chk(fifo_wr_o, 1'b0);
		bus(IDX_FRAMING_CTRL, 1'b1, 32'hC0);
		ev_pulse(7'h10, ~d, 1'b1);
		chk({fifo_wr_o, fifo_wdata_o}, {1'b1, ~d});
		ev_pulse(7'h40, 8'h00, 1'b0);
		chk({fifo_wr_o, fifo_wdata_o}, {1'b1, er});
		settle();
		chk(receiver_active_o, 1'b1);
		bus(IDX_IRQ_STATUS, 1'b0, 32'h0);
		chk(rdata & 32'h7, 32'h1);
		chk(irq_o, 1'b0);
		bus(IDX_IRQ_MASK, 1'b1, 32'h1);
		settle();
		chk(irq_o, 1'b1);
		bus(IDX_IRQ_STATUS, 1'b1, 32'h1);
		settle();
		chk(irq_o, 1'b0);
		ev_pulse(7'h02, 8'h00, 1'b0);
		bus(IDX_FRAMING_CTRL, 1'b1, 32'h08);
		ev_pulse(7'h01, 8'h00, 1'b0);
		ev_pulse(7'h08, 8'h00, 1'b0);
		ev_pulse(7'h10, d, 1'b0);
		settle();
		chk(fifo_read_safe_o, 1'b0);
		ev_pulse(7'h20, 8'h00, 1'b0);
		chk(fifo_reset_o, 1'b1);
		ev_pulse(7'h08, 8'h00, 1'b0);
		ev_pulse(7'h10, d, 1'b0);
		ev_pulse(7'h10, d, 1'b0);
		ev_pulse(7'h40, 8'h00, 1'b0);
		chk(fifo_reset_o, 1'b1);
		bus(IDX_IRQ_STATUS, 1'b0, 32'h0);
		chk(rdata & 32'h7, 32'h2);
		chk(irq_o, 1'b0);
		bus(IDX_IRQ_STATUS, 1'b1, 32'h7);
		ev_pulse(7'h08, 8'h00, 1'b0);
		repeat (3) ev_pulse(7'h10, 8'($random(seed)), 1'b0);
		settle();
		chk(fifo_read_safe_o, 1'b1);
		ev_pulse(7'h40, 8'h00, 1'b0);
		chk(fifo_reset_o, 1'b0);
		bus(IDX_IRQ_STATUS, 1'b0, 32'h0);
		chk(rdata & 32'h7, 32'h1);
		chk(irq_o, 1'b1);
		bus(IDX_IRQ_STATUS, 1'b1, 32'h7);
		guard(8'h01, 48);
		guard(8'h02, 96);
		guard(8'h81, half_t[code]);
		guard(8'h00, 0);
		bus(IDX_IRQ_STATUS, 1'b0, 32'h0);
		chk(rdata & 32'h4, 32'h4);
		give_verdict();
	end
endmodule // testbench
